// ---- design/cpm_top.sv ----
// clock path mode configuration: axi4-lite registers and path control
//
// What this block does
// - loop power field 00b runs the loop, 01b powers it down.
// - source bit 1 picks the internal oscillator, 0 the external input.
// - bypass bit 0 uses the post divider, 1 feeds distribution directly.
// - the post divider offers whole ratios one through six.
// - polarity bit 0 is positive, 1 is negative loop polarity.
// - reset gives loop down, divider 000b, divider in path, external in.
// - loop on with external input powers the oscillator off.
// - settings can be saved to storage and come back after a later reset.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module cpm_top
  import cpm_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // clock path controls
  output logic                   loop_enable,
  output logic                   loop_polarity_neg,
  output logic                   osc_select,
  output logic                   osc_power_on,
  output logic                   div_bypass,
  output logic      [2:0]        div_ratio,
  output logic                   div_tick,
  output logic      [2:0]        ref_enable,
  output logic                   cal_start
);

  //////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    cpm_cfg_t          stage;
    cpm_cfg_t          act;
    logic              cal_start;
    logic              restored;
    logic              save;
  } cpm_st_t;

  cpm_st_t  st_reg;
  cpm_st_t  st_next;
  logic     nvm_valid;
  cpm_cfg_t nvm_cfg;
  logic [2:0] ratio_w;
  logic       tick_w;

  // byte address to register index; low bits must be zero for a hit
  function automatic logic [9:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = 10'(a >> 2);
  endfunction : addr_idx

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [9:0] i;
    i = addr_idx(a);
    addr_ok = (a[1:0] == 2'h0) &&
      (i == CPM_IDX_LOOP || i == CPM_IDX_CAL || i == CPM_IDX_REFEN ||
       i == CPM_IDX_DIV  || i == CPM_IDX_SRC || i == CPM_IDX_XFER  ||
       i == CPM_IDX_NVM  || i == CPM_IDX_STAT);
  endfunction : addr_ok

  //////////////////////////////////////////////////////////////////////////
  // helpers

  cpm_nvm u_nvm (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .save     (st_reg.save),
    .save_cfg (st_reg.act),
    .valid    (nvm_valid),
    .stored   (nvm_cfg)
  );

  cpm_postdiv u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .div_code (st_reg.act.div[2:0]),
    .bypass   (st_reg.act.src[CPM_SRC_BYP_BIT]),
    .ratio    (ratio_w),
    .div_tick (tick_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [9:0] widx;
    logic [9:0] ridx;
    logic       wbit0;
    logic       cal_was;
    widx    = addr_idx(st_reg.aw_addr);
    // a refused read address falls to the default branch and returns zero
    ridx    = addr_ok(s_axi_araddr) ? addr_idx(s_axi_araddr) : 10'h3ff;
    wbit0   = st_reg.w_data[0] & st_reg.w_strb[0];
    cal_was = st_reg.act.cal[CPM_CAL_BIT];
    st_next = st_reg;
    st_next.cal_start = 1'b0;
    st_next.save      = 1'b0;

    // one cycle after reset, pull the stored image if there is one
    if (!st_reg.restored) begin
      st_next.restored = 1'b1;
      if (nvm_valid) begin
        st_next.stage = nvm_cfg;
        st_next.act   = nvm_cfg;
      end
    end

    // address and data are taken in either order, one of each at a time
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // perform a write once both halves are held and no response is pending
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = addr_ok(st_reg.aw_addr) ? CPM_RESP_OKAY
                                                 : CPM_RESP_SLVERR;
      if (addr_ok(st_reg.aw_addr) && st_reg.w_strb[0]) begin
        // writes land in the staging copy only
        case (widx)
          CPM_IDX_LOOP:  st_next.stage.loop  = st_reg.w_data[7:0];
          CPM_IDX_CAL:   st_next.stage.cal   = st_reg.w_data[7:0];
          CPM_IDX_REFEN: st_next.stage.refen = st_reg.w_data[7:0];
          CPM_IDX_DIV:   st_next.stage.div   = st_reg.w_data[7:0];
          CPM_IDX_SRC:   st_next.stage.src   = st_reg.w_data[7:0];
          default: ;
        endcase
      end
      if (addr_ok(st_reg.aw_addr) && widx == CPM_IDX_XFER && wbit0) begin
        // strobe copies staging to active; a 0 to 1 on the cal bit kicks
        // calibration, so a re-run needs a clear-and-strobe first
        st_next.act = st_next.stage;
        st_next.cal_start = st_next.stage.cal[CPM_CAL_BIT] &
                            ~cal_was;
      end
      if (addr_ok(st_reg.aw_addr) && widx == CPM_IDX_NVM &&
          st_reg.w_data[CPM_NVM_SAVE_BIT] && st_reg.w_strb[0]) begin
        st_next.save = 1'b1;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // reads show the staged values; status shows what is live
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = addr_ok(s_axi_araddr) ? CPM_RESP_OKAY
                                              : CPM_RESP_SLVERR;
      case (ridx)
        CPM_IDX_LOOP:  st_next.rdata = {24'h0, st_reg.stage.loop};
        CPM_IDX_CAL:   st_next.rdata = {24'h0, st_reg.stage.cal};
        CPM_IDX_REFEN: st_next.rdata = {24'h0, st_reg.stage.refen};
        CPM_IDX_DIV:   st_next.rdata = {24'h0, st_reg.stage.div};
        CPM_IDX_SRC:   st_next.rdata = {24'h0, st_reg.stage.src};
        CPM_IDX_NVM:   st_next.rdata = {31'h0, nvm_valid};
        CPM_IDX_STAT:  st_next.rdata = {24'h0, osc_power_on, ratio_w,
                                        osc_select, div_bypass,
                                        loop_polarity_neg, loop_enable};
        default:       st_next.rdata = 32'h0;
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; reset values give loop down, divider code 000b,
  // divider in path, external input selected

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.stage    <= CPM_CFG_RESET;
      st_reg.act      <= CPM_CFG_RESET;
    end else if (ce) begin
      st_reg          <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // bus handshakes: one held address and one held data, one read at a time;
  // a frozen block shows no handshake, since it could not complete it
  assign s_axi_awready = !st_reg.aw_full && ce;
  assign s_axi_wready  = !st_reg.w_full && ce;
  assign s_axi_bvalid  = st_reg.bvalid && ce;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid && ce;
  assign s_axi_rvalid  = st_reg.rvalid && ce;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = st_reg.rdata;

  // path controls decoded from the active copy; the reserved 1x codes of
  // loop power also keep the loop off, the safe choice
  assign loop_enable = st_reg.act.loop[CPM_LOOP_PWR_LSB +: 2]
                       == CPM_PWR_NORMAL;
  assign loop_polarity_neg = st_reg.act.loop[CPM_LOOP_POL_BIT];
  assign osc_select  = st_reg.act.src[CPM_SRC_INT_BIT];
  assign div_bypass  = st_reg.act.src[CPM_SRC_BYP_BIT];
  // oscillator is powered only when the loop runs from it
  assign osc_power_on = loop_enable & osc_select;
  assign div_ratio   = ratio_w;
  assign div_tick    = tick_w & ce;
  assign ref_enable  = st_reg.act.refen[2:0];
  // pulses only in an enabled cycle, so a freeze cannot stretch it
  assign cal_start   = st_reg.cal_start & ce;

endmodule : cpm_top
`default_nettype wire

// ---- design/cpm_pkg.sv ----
// shared constants and types for the clock path mode configuration block
package cpm_pkg;

  // register byte offsets (some are not multiples of four, so these are
  // indices and the byte address is four times the index)
  localparam logic [9:0] CPM_IDX_LOOP   = 10'h010;
  localparam logic [9:0] CPM_IDX_CAL    = 10'h018;
  localparam logic [9:0] CPM_IDX_REFEN  = 10'h01c;
  localparam logic [9:0] CPM_IDX_DIV    = 10'h1e0;
  localparam logic [9:0] CPM_IDX_SRC    = 10'h1e1;
  localparam logic [9:0] CPM_IDX_XFER   = 10'h232;
  localparam logic [9:0] CPM_IDX_NVM    = 10'h300;
  localparam logic [9:0] CPM_IDX_STAT   = 10'h301;

  // field positions
  localparam int CPM_LOOP_PWR_LSB = 0;
  localparam int CPM_LOOP_POL_BIT = 7;
  localparam int CPM_CAL_BIT      = 0;
  localparam int CPM_SRC_INT_BIT  = 1;
  localparam int CPM_SRC_BYP_BIT  = 0;
  localparam int CPM_XFER_BIT     = 0;
  localparam int CPM_NVM_SAVE_BIT = 0;

  // loop power encodings
  localparam logic [1:0] CPM_PWR_NORMAL = 2'h0;
  localparam logic [1:0] CPM_PWR_DOWN   = 2'h1;

  // reset values
  localparam logic [7:0] CPM_RST_LOOP  = 8'h01;
  localparam logic [7:0] CPM_RST_CAL   = 8'h00;
  localparam logic [7:0] CPM_RST_REFEN = 8'h00;
  localparam logic [7:0] CPM_RST_DIV   = 8'h00;
  localparam logic [7:0] CPM_RST_SRC   = 8'h00;

  // axi responses
  localparam logic [1:0] CPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CPM_RESP_SLVERR = 2'h2;

  // nonvolatile image: five configuration bytes
  localparam int CPM_NVM_WORDS = 5;

  // settings as one bundle, shared by staging, active and stored copies
  typedef struct packed {
    logic [7:0] loop;
    logic [7:0] cal;
    logic [7:0] refen;
    logic [7:0] div;
    logic [7:0] src;
  } cpm_cfg_t;

  localparam cpm_cfg_t CPM_CFG_RESET = '{
    loop: CPM_RST_LOOP, cal: CPM_RST_CAL, refen: CPM_RST_REFEN,
    div: CPM_RST_DIV, src: CPM_RST_SRC};

endpackage : cpm_pkg

// ---- design/cpm_postdiv.sv ----
// post-oscillator divider ratio decode and divided-clock enable counter
`timescale 1ns/1ns
`default_nettype none
module cpm_postdiv
  import cpm_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // control
  input  wire logic [2:0] div_code,
  input  wire logic       bypass,
  // result
  output logic     [2:0]  ratio,
  output logic            div_tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic [2:0] ratio;
    logic       tick;
  } cpm_div_st_t;

  cpm_div_st_t st_reg;
  cpm_div_st_t st_next;

  // code 000b gives two, 001b..101b give one..five, 110b up give six
  function automatic logic [2:0] code_to_ratio(input logic [2:0] c);
    case (c)
      3'h0:    code_to_ratio = 3'h2;
      3'h1:    code_to_ratio = 3'h1;
      3'h2:    code_to_ratio = 3'h2;
      3'h3:    code_to_ratio = 3'h3;
      3'h4:    code_to_ratio = 3'h4;
      3'h5:    code_to_ratio = 3'h5;
      default: code_to_ratio = 3'h6;
    endcase
  endfunction : code_to_ratio

  // bypass forces ratio one; the counter emits one tick per ratio cycles
  always_comb begin
    st_next = st_reg;
    st_next.ratio = bypass ? 3'h1 : code_to_ratio(div_code);
    if (st_reg.cnt + 3'h1 >= st_next.ratio) begin
      st_next.cnt  = 3'h0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt  = st_reg.cnt + 3'h1;
      st_next.tick = 1'b0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{cnt: 3'h0, ratio: 3'h2, tick: 1'b0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign ratio    = st_reg.ratio;
  assign div_tick = st_reg.tick;

endmodule : cpm_postdiv
`default_nettype wire

// ---- design/cpm_nvm.sv ----
// small nonvolatile configuration store with save and restore after reset
`timescale 1ns/1ns
`default_nettype none
module cpm_nvm
  import cpm_pkg::*;
(
  // clock and reset
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire logic     ce,
  // save request
  input  wire logic     save,
  input  wire cpm_cfg_t save_cfg,
  // restore result
  output logic          valid,
  output cpm_cfg_t      stored
);

  // the store is cleared only by the first reset, not by later ones, as flash would not be; valid tells
  // whether it has ever been written since the model came up
  typedef struct packed {
    cpm_cfg_t img;
    logic     valid;
  } cpm_nvm_st_t;

  cpm_nvm_st_t st_reg;
  cpm_nvm_st_t st_next;
  // starts clear at power-up so the very first reset empties the store
  logic        seen_reg = 1'b0;

  // capture the whole image on a save request
  always_comb begin
    st_next = st_reg;
    if (save) begin
      st_next.img   = save_cfg;
      st_next.valid = 1'b1;
    end
  end

  // image survives reset; only the first-ever reset marks it empty
  always_ff @(posedge aclk) begin
    if (!aresetn && !seen_reg) begin
      st_reg   <= '{img: CPM_CFG_RESET, valid: 1'b0};
    end else if (aresetn && ce) begin
      st_reg   <= st_next;
    end
  end

  // remembers that a first reset has been seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_reg <= 1'b1;
    end
  end

  assign valid  = st_reg.valid;
  assign stored = st_reg.img;

endmodule : cpm_nvm
`default_nettype wire

// ---- tb/cpm_top_chk.sv ----
// assertion checker for the clock path mode configuration block
`timescale 1ns/1ns
`default_nettype none
module cpm_top_chk (
  // clock, reset, enable
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  // bus handshakes
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_rvalid,
  // clock path controls
  input wire logic       loop_enable,
  input wire logic       loop_polarity_neg,
  input wire logic       osc_select,
  input wire logic       osc_power_on,
  input wire logic       div_bypass,
  input wire logic [2:0] div_ratio,
  input wire logic       cal_start
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a write is complete when its response first shows
  sequence s_write_done;
    $rose(s_axi_bvalid);
  endsequence

  // active path settings as one group; restore after reset is exempt
  logic [4:0] path_now;
  assign path_now = {loop_enable, loop_polarity_neg, osc_select,
                     div_bypass, osc_power_on};

  //////////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property ($rose(aresetn) |->
    !loop_enable && !osc_select && !div_bypass && div_ratio == 3'h2)
    else $error("path not at defaults after reset");
  a_osc_power: assert property (
    osc_power_on == (loop_enable && osc_select))
    else $error("oscillator power does not follow loop and source");
  a_ratio_range: assert property (
    div_ratio >= 3'h1 && div_ratio <= 3'h6)
    else $error("divider ratio outside one to six");
  a_bypass_ratio: assert property (div_bypass && ce |=>
    div_ratio == 3'h1)
    else $error("bypass does not give ratio one");
  a_cal_pulse: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
  a_cal_cause: assert property (cal_start |-> s_write_done)
    else $error("calibration start without a completed write");
  a_path_staged: assert property ($changed(path_now) &&
    $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3)
    |-> s_write_done)
    else $error("active path changed outside a transfer");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready ##1 ce |->
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    ##1 ce |-> s_axi_rvalid)
    else $error("read data not one cycle after address");
endmodule : cpm_top_chk

bind cpm_top cpm_top_chk u_chk (.aclk, .aresetn, .ce, .s_axi_arvalid,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .loop_enable, .loop_polarity_neg, .osc_select, .osc_power_on, .div_bypass,
  .div_ratio, .cal_start);
`default_nettype wire

// ---- tb/cpm_bench.sv ----
// self-checking bench for the clock path mode configuration block
`timescale 1ns/1ns
`default_nettype none
module cpm_bench;
  import cpm_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cal_seen;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        loop_enable, loop_polarity_neg, osc_select, osc_power_on;
  logic        div_bypass, cal_start, div_tick;
  logic [2:0]  div_ratio, ref_enable, er;
  int          num_errors = 0, checks = 0, ticks = 0;

  // 25 MHz clock
  always #20 aclk = ~aclk;

  cpm_top #(.ADDR_W(12)) DUT (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .loop_enable, .loop_polarity_neg, .osc_select, .osc_power_on,
    .div_bypass, .div_ratio, .div_tick, .ref_enable, .cal_start);

  //////////////////////////////////////////////////////////////////////////////
  // verdict and the one place the run ends
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // compare any result, unknowns never match
  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  // a handshake that never comes ends the run
  task automatic bound(input int n);
    if (n >= 40) begin
      num_errors++;
      $display("mismatch handshake expected answer seen none");
      complete_run();
    end
  endtask : bound

  // one write; ready low after the response so no double assignment
  task automatic axi_wr(input logic [9:0] i, input logic [7:0] v,
                        output logic [1:0] resp);
    int n;
    n = 0;
    cal_seen = 1'h0;
    @(posedge aclk);
    s_axi_awaddr  <= {i, 2'h0};
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      bound(n);
      cal_seen = cal_seen | cal_start;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    #1;
  endtask : axi_wr

  // one read
  task automatic axi_rd(input logic [9:0] i, output logic [31:0] v,
                        output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      bound(n);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    #1;
  endtask : axi_rd

  // checked register access and path output snapshot
  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    axi_wr(i, v, r);
    cmp("bresp", {30'h0, CPM_RESP_OKAY}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    axi_rd(i, d, r);
    cmp("rdata", e, d);
    cmp("rresp", {30'h0, CPM_RESP_OKAY}, {30'h0, r});
  endtask : rd
  task automatic outs(input logic [7:0] e);
    cmp("path", {24'h0, e}, {24'h0, loop_enable, loop_polarity_neg,
        osc_select, osc_power_on, div_bypass, div_ratio});
  endtask : outs

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    #1;
    outs(8'h02);
    rd(CPM_IDX_LOOP, 32'h01);
    rd(CPM_IDX_DIV, 32'h00);
    rd(CPM_IDX_SRC, 32'h00);
    wr(CPM_IDX_LOOP, 8'h80);
    wr(CPM_IDX_SRC, 8'h02);
    wr(CPM_IDX_REFEN, 8'h05);
    outs(8'h02);
    rd(CPM_IDX_LOOP, 32'h80);
    wr(CPM_IDX_XFER, 8'h01);
    outs(8'hf2);
    cmp("ref_enable", 32'h5, {29'h0, ref_enable});
    wr(CPM_IDX_LOOP, 8'h01);
    wr(CPM_IDX_XFER, 8'h01);
    outs(8'h22);
    wr(CPM_IDX_SRC, 8'h00);
    wr(CPM_IDX_LOOP, 8'h00);
    wr(CPM_IDX_XFER, 8'h01);
    outs(8'h82);
    // every divider code, last one left staged for the restore test
    for (int c = 0; c < 8; c++) begin
      er = (c == 0) ? 3'h2 : (c > 5) ? 3'h6 : c[2:0];
      wr(CPM_IDX_DIV, c[7:0]);
      wr(CPM_IDX_XFER, 8'h01);
      outs({5'h10, er});
    end
    wr(CPM_IDX_SRC, 8'h01);
    wr(CPM_IDX_XFER, 8'h01);
    outs(8'h89);
    rd(CPM_IDX_STAT, 32'h15);
    // first calibration, a repeat strobe, then clear and set again
    wr(CPM_IDX_CAL, 8'h01);
    wr(CPM_IDX_XFER, 8'h01);
    cmp("cal_start", 32'h1, {31'h0, cal_seen});
    wr(CPM_IDX_XFER, 8'h01);
    cmp("cal_start", 32'h0, {31'h0, cal_seen});
    wr(CPM_IDX_CAL, 8'h00);
    wr(CPM_IDX_XFER, 8'h01);
    wr(CPM_IDX_CAL, 8'h01);
    wr(CPM_IDX_XFER, 8'h01);
    cmp("cal_start", 32'h1, {31'h0, cal_seen});
    // unmapped places answer with an error and change nothing
    axi_rd(10'h001, d, r);
    cmp("rresp", {30'h0, CPM_RESP_SLVERR}, {30'h0, r});
    cmp("rdata", 32'h0, d);
    axi_wr(10'h3ff, 8'hff, r);
    cmp("bresp", {30'h0, CPM_RESP_SLVERR}, {30'h0, r});
    // a frozen block takes no request until the enable returns
    ce <= 1'h0;
    fork
      wr(CPM_IDX_REFEN, 8'h03);
      begin
        repeat (4) @(posedge aclk);
        cmp("awready", 32'h0, {31'h0, s_axi_awready});
        ce <= 1'h1;
      end
    join
    rd(CPM_IDX_REFEN, 32'h03);
    // save, reset, and expect the saved path back without host writes
    wr(CPM_IDX_SRC, 8'h02);
    wr(CPM_IDX_XFER, 8'h01);
    outs(8'hb6);
    wr(CPM_IDX_NVM, 8'h01);
    rd(CPM_IDX_NVM, 32'h01);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    #1;
    outs(8'hb6);
    // at ratio six the divided clock ticks twice in twelve cycles
    repeat (12) begin
      @(posedge aclk);
      ticks += div_tick;
    end
    cmp("div_tick", 32'h2, ticks);
    complete_run();
  end
endmodule : cpm_bench
`default_nettype wire
